// file: hw/fts_top.sv
// What this block does
// - overheat is checked before low temperature in ready and printing
// - a single detection is only pending; a repeat makes it final
// - ready: roller overheat gives C449 with counter 23
// - printing: overheat C449/25, then cold roller C447, cold press C467
// - energy saving: overheat C449/27, pressure roller hot C468/26
// - paper jam: overheat C449/29, pressure roller hot C468/28
// - motor runs while run line is low, stops when high
// - slow line low selects low speed, high selects high speed
// - ready and pressure roller below reference drives slow line low
// - a divided reference clock is driven to the motor
// - lock when feedback period within 6.25 percent of reference
// - hall inputs step the excitation phases while running
`timescale 1ns/100ps
`default_nettype none
`include "fts_consts.svh"

module fts_top import fts_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // interrupt
    output logic irq,
    // thermistor readings
    input wire fts_temps_t temps_raw,
    // motor driver board
    input wire logic [2:0] hall,
    input wire logic rotation_feedback_pulse,
    output logic fuser_motor_run_n,
    output logic fuser_motor_slow_n,
    output logic fuser_speed_ref_clock,
    output logic [5:0] phase_drive,
    output logic lock_led
);

    default clocking fts_cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    fts_temps_t temps_s1;
    fts_temps_t temps;
    logic [2:0] hall_s1;
    logic [2:0] hall_s;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temps_s1 <= '0;
            temps <= '0;
            hall_s1 <= 3'h0;
            hall_s <= 3'h0;
        end else begin
            temps_s1 <= temps_raw;
            temps <= temps_s1;
            hall_s1 <= hall;
            hall_s <= hall_s1;
        end
    end

    // ------------------------------------------------------------
    // bus slave and control registers
    // ------------------------------------------------------------
    fts_phase_t phase;
    fts_phase_t next_phase;
    logic run;
    logic next_run;
    logic force_slow;
    logic next_force_slow;
    logic [9:0] slow_ref;
    logic [9:0] next_slow_ref;
    logic [15:0] ref_half;
    logic [15:0] next_ref_half;
    logic [2:0] irq_en;
    logic [2:0] next_irq_en;
    logic [31:0] next_readdata;
    logic next_wait;
    logic acc;
    logic wr_ctrl;
    logic clr_fault;
    logic [2:0] clr_stat;
    fts_fault_t fault;
    fts_fault_t pend;
    logic [2:0] irq_stat;
    logic [16:0] period;

    function automatic logic fts_wr(input logic [5:0] a, input logic [5:0] o,
                                    input logic w, input logic k);
        fts_wr = w && k && a == o;
    endfunction

    always_comb begin
        acc = (read || write) && !waitrequest;
        wr_ctrl = fts_wr(address, `FTS_OFF_CTRL, write, acc);
        clr_fault = fts_wr(address, `FTS_OFF_FAULT, write, acc);
        clr_stat = fts_wr(address, `FTS_OFF_IRQ_CLR, write, acc)
            ? writedata[2:0] : 3'h0;
        next_wait = !((read || write) && waitrequest);
        next_phase = phase;
        next_run = run;
        next_force_slow = force_slow;
        next_slow_ref = slow_ref;
        next_ref_half = ref_half;
        next_irq_en = irq_en;
        if (wr_ctrl) begin
            unique case (writedata[4:0])
                5'h01, 5'h02, 5'h04, 5'h08, 5'h10: begin
                    next_phase = fts_phase_t'(writedata[4:0]);
                end
                default: begin
                    next_phase = FTS_IDLE;
                end
            endcase
            next_run = writedata[`FTS_CTRL_RUN];
            next_force_slow = writedata[`FTS_CTRL_SLOW];
        end
        if (fts_wr(address, `FTS_OFF_SLOW_REF, write, acc)) begin
            next_slow_ref = writedata[9:0];
        end
        if (fts_wr(address, `FTS_OFF_REF_HALF, write, acc)) begin
            next_ref_half = writedata[15:0];
        end
        if (fts_wr(address, `FTS_OFF_IRQ_EN, write, acc)) begin
            next_irq_en = writedata[2:0];
        end
        next_readdata = readdata;
        if (read && waitrequest) begin
            unique case (address)
                `FTS_OFF_CTRL: next_readdata = {22'h0, force_slow, run,
                                                3'h0, phase};
                `FTS_OFF_SLOW_REF: next_readdata = {22'h0, slow_ref};
                `FTS_OFF_REF_HALF: next_readdata = {16'h0, ref_half};
                `FTS_OFF_FAULT: next_readdata = {fault.hit, pend.hit,
                                                 6'h0, fault.count,
                                                 fault.code};
                `FTS_OFF_PEND: next_readdata = {pend.hit, 7'h0,
                                                pend.count, pend.code};
                `FTS_OFF_MOTOR: next_readdata = {lock_led, 14'h0, period};
                `FTS_OFF_IRQ_STAT: next_readdata = {29'h0, irq_stat};
                `FTS_OFF_IRQ_EN: next_readdata = {29'h0, irq_en};
                default: next_readdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase <= FTS_IDLE;
            run <= 1'b0;
            force_slow <= 1'b0;
            slow_ref <= `FTS_SLOW_REF_RST;
            ref_half <= `FTS_REF_HALF_RST;
            irq_en <= 3'h0;
            readdata <= 32'h0;
            waitrequest <= 1'b1;
        end else begin
            phase <= next_phase;
            run <= next_run;
            force_slow <= next_force_slow;
            slow_ref <= next_slow_ref;
            ref_half <= next_ref_half;
            irq_en <= next_irq_en;
            readdata <= next_readdata;
            waitrequest <= next_wait;
        end
    end

    // ------------------------------------------------------------
    // fault judging, confirmation and interrupts
    // ------------------------------------------------------------
    fts_fault_t judge;
    fts_fault_t next_fault;
    fts_fault_t next_pend;
    logic [2:0] next_irq_stat;
    logic [2:0] ev;
    logic next_irq;
    logic latch;
    logic lock_prev;

    fts_judge fts_judge_i (
        .phase(phase),
        .t(temps),
        .hit(judge)
    );

    always_comb begin
        latch = judge.hit && pend.hit && judge == pend && !fault.hit;
        // once latched, nothing new is pended or latched
        next_pend = fault.hit ? '0 : judge;
        next_fault = fault;
        if (latch) begin
            next_fault = judge;
        end else if (clr_fault) begin
            next_fault = '0;
        end
        ev = {lock_prev && !lock_led,
              judge.hit && !pend.hit && !fault.hit,
              latch};
        next_irq_stat = (irq_stat & ~clr_stat) | ev;
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault <= '0;
            pend <= '0;
            irq_stat <= 3'h0;
            irq <= 1'b0;
            lock_prev <= 1'b0;
        end else begin
            fault <= next_fault;
            pend <= next_pend;
            irq_stat <= next_irq_stat;
            irq <= next_irq;
            lock_prev <= lock_led;
        end
    end

    // ------------------------------------------------------------
    // motor control
    // ------------------------------------------------------------
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic next_ref_clock;
    logic next_run_n;
    logic next_slow_n;
    logic slow_cond;
    logic [5:0] next_phase_drive;

    // six step table, bits are a+ a- b+ b- c+ c-
    function automatic logic [5:0] fts_commutate(input logic [2:0] h);
        unique case (h)
            3'h5: fts_commutate = 6'h24;
            3'h4: fts_commutate = 6'h21;
            3'h6: fts_commutate = 6'h09;
            3'h2: fts_commutate = 6'h18;
            3'h3: fts_commutate = 6'h12;
            3'h1: fts_commutate = 6'h06;
            default: fts_commutate = 6'h00;
        endcase
    endfunction

    always_comb begin
        next_run_n = !run;
        slow_cond = force_slow
            || (phase == FTS_READY && temps.press < $signed(slow_ref));
        next_slow_n = !slow_cond;
        next_phase_drive = run ? fts_commutate(hall_s) : 6'h00;
        next_div_cnt = div_cnt + 16'h0001;
        next_ref_clock = fuser_speed_ref_clock;
        if ({1'b0, div_cnt} + 17'h00001 >= {1'b0, ref_half}) begin
            next_div_cnt = 16'h0000;
            next_ref_clock = !fuser_speed_ref_clock;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fuser_motor_run_n <= 1'b1;
            fuser_motor_slow_n <= 1'b1;
            phase_drive <= 6'h00;
            div_cnt <= 16'h0000;
            fuser_speed_ref_clock <= 1'b0;
        end else begin
            fuser_motor_run_n <= next_run_n;
            fuser_motor_slow_n <= next_slow_n;
            phase_drive <= next_phase_drive;
            div_cnt <= next_div_cnt;
            fuser_speed_ref_clock <= next_ref_clock;
        end
    end

    fts_lock_meter fts_lock_meter_i (
        .clock(clock),
        .rst_b(rst_b),
        .feedback(rotation_feedback_pulse),
        .ref_period({ref_half, 1'b0}),
        .lock(lock_led),
        .period(period)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_hot_first: assert property (phase == FTS_READY
        && temps.center >= $signed(`FTS_T_CENTER_HOT)
        |-> judge.code == `FTS_C449 && judge.count == 8'h17)
        else $error("ready overheat not reported as C449/23");

    a_ready_cold_code: assert property (phase == FTS_READY
        && temps.front <= $signed(`FTS_T_ROLL_COLD)
        && temps.center < $signed(`FTS_T_CENTER_HOT)
        && temps.rear < $signed(`FTS_T_REAR_HOT)
        |-> judge.code == `FTS_C447 && judge.count == 8'h07)
        else $error("ready cold roller not reported as C447/7");

    a_print_hot_code: assert property (phase == FTS_PRINT
        && temps.rear >= $signed(`FTS_T_REAR_HOT)
        |-> judge.code == `FTS_C449 && judge.count == 8'h19)
        else $error("print overheat not reported as C449/25");

    a_save_press_hot: assert property (phase == FTS_SAVE && !judge.hit
        |-> temps.press < $signed(10'h0FA) && temps.center < $signed(10'h0F0))
        else $error("energy saving violation missed");

    a_jam_press_code: assert property (phase == FTS_JAM
        && judge.code == `FTS_C468
        |-> judge.count == 8'h1C && temps.front < $signed(10'h10E))
        else $error("jam pressure code or priority wrong");

    a_single_pending: assert property (!pend.hit && !fault.hit
        |=> !fault.hit)
        else $error("fault finalised on first detection");

    a_fault_held: assert property (fault.hit && !clr_fault
        |=> $stable(fault))
        else $error("latched fault changed without clear");

    a_run_pin: assert property (run ##1 run |-> !fuser_motor_run_n)
        else $error("run line not low while running");

    a_slow_ready: assert property (phase == FTS_READY
        && temps.press < $signed(slow_ref) |=> !fuser_motor_slow_n)
        else $error("slow line not low on cool pressure roller");

    a_fast_high: assert property (!slow_cond |=> fuser_motor_slow_n)
        else $error("slow line low without cause");

    a_ref_toggle: assert property (ref_half == 16'h0014
        && $stable(ref_half) |-> ##[1:20] $changed(fuser_speed_ref_clock))
        else $error("reference clock stalled");

    a_stop_drive: assert property (!run |=> phase_drive == 6'h00)
        else $error("phases driven while stopped");

endmodule // fts_top
`default_nettype wire

// file: hw/fts_consts.svh
`ifndef FTS_CONSTS_SVH
`define FTS_CONSTS_SVH

// register byte offsets
`define FTS_OFF_CTRL 6'h00
`define FTS_OFF_SLOW_REF 6'h04
`define FTS_OFF_REF_HALF 6'h08
`define FTS_OFF_FAULT 6'h0C
`define FTS_OFF_PEND 6'h10
`define FTS_OFF_MOTOR 6'h14
`define FTS_OFF_IRQ_STAT 6'h18
`define FTS_OFF_IRQ_CLR 6'h1C
`define FTS_OFF_IRQ_EN 6'h20

// control field positions
`define FTS_CTRL_RUN 8
`define FTS_CTRL_SLOW 9

// reset values
`define FTS_SLOW_REF_RST 10'h0B4
`define FTS_REF_HALF_RST 16'h01F4

// temperature limits, degrees C, signed 10 bit
`define FTS_T_CENTER_HOT 10'h0F0
`define FTS_T_REAR_HOT 10'h0FA
`define FTS_T_FRONT_HOT 10'h10E
`define FTS_T_PRESS_HOT 10'h0FA
`define FTS_T_ROLL_COLD 10'h028
`define FTS_T_PRESS_COLD 10'h000

// error codes and diagnostic counter values
`define FTS_C447 16'h0447
`define FTS_C449 16'h0449
`define FTS_C467 16'h0467
`define FTS_C468 16'h0468
`define FTS_CNT_READY_HOT 8'h17
`define FTS_CNT_READY_COLD 8'h07
`define FTS_CNT_PRINT 8'h19
`define FTS_CNT_SAVE_HOT 8'h1B
`define FTS_CNT_SAVE_PRESS 8'h1A
`define FTS_CNT_JAM_HOT 8'h1D
`define FTS_CNT_JAM_PRESS 8'h1C

// lock band: period / 16 is 6.25 percent
`define FTS_LOCK_SHIFT 4
`define FTS_PERIOD_MAX 17'h1FFFF

`endif

// file: hw/fts_pkg.sv
package fts_pkg;

    typedef enum logic [4:0] {
        FTS_IDLE = 5'h01,
        FTS_READY = 5'h02,
        FTS_PRINT = 5'h04,
        FTS_SAVE = 5'h08,
        FTS_JAM = 5'h10
    } fts_phase_t;

    typedef struct packed {
        logic signed [9:0] center;
        logic signed [9:0] rear;
        logic signed [9:0] front;
        logic signed [9:0] press;
    } fts_temps_t;

    typedef struct packed {
        logic hit;
        logic [15:0] code;
        logic [7:0] count;
    } fts_fault_t;

endpackage

// file: hw/fts_judge.sv
`timescale 1ns/100ps
`default_nettype none
`include "fts_consts.svh"

module fts_judge import fts_pkg::*; (
    // machine phase and readings
    input wire fts_phase_t phase,
    input wire fts_temps_t t,
    // highest priority violation
    output var fts_fault_t hit
);

    logic hot;
    logic cold;
    logic p_cold;
    logic p_hot;

    always_comb begin
        hot = t.center >= $signed(`FTS_T_CENTER_HOT)
            || t.rear >= $signed(`FTS_T_REAR_HOT)
            || t.front >= $signed(`FTS_T_FRONT_HOT);
        cold = t.center <= $signed(`FTS_T_ROLL_COLD)
            || t.rear <= $signed(`FTS_T_ROLL_COLD)
            || t.front <= $signed(`FTS_T_ROLL_COLD);
        p_cold = t.press <= $signed(`FTS_T_PRESS_COLD);
        p_hot = t.press >= $signed(`FTS_T_PRESS_HOT);
        hit = '0;
        // overheat first, then the lower priority checks
        unique case (phase)
            FTS_READY: begin
                if (hot) begin
                    hit = {1'b1, `FTS_C449, `FTS_CNT_READY_HOT};
                end else if (cold) begin
                    hit = {1'b1, `FTS_C447, `FTS_CNT_READY_COLD};
                end else if (p_cold) begin
                    hit = {1'b1, `FTS_C467, `FTS_CNT_READY_COLD};
                end
            end
            FTS_PRINT: begin
                if (hot) begin
                    hit = {1'b1, `FTS_C449, `FTS_CNT_PRINT};
                end else if (cold) begin
                    hit = {1'b1, `FTS_C447, `FTS_CNT_PRINT};
                end else if (p_cold) begin
                    hit = {1'b1, `FTS_C467, `FTS_CNT_PRINT};
                end
            end
            FTS_SAVE: begin
                if (hot) begin
                    hit = {1'b1, `FTS_C449, `FTS_CNT_SAVE_HOT};
                end else if (p_hot) begin
                    hit = {1'b1, `FTS_C468, `FTS_CNT_SAVE_PRESS};
                end
            end
            FTS_JAM: begin
                if (hot) begin
                    hit = {1'b1, `FTS_C449, `FTS_CNT_JAM_HOT};
                end else if (p_hot) begin
                    hit = {1'b1, `FTS_C468, `FTS_CNT_JAM_PRESS};
                end
            end
            default: begin
                hit = '0;
            end
        endcase
    end

endmodule // fts_judge
`default_nettype wire

// file: hw/fts_lock_meter.sv
`timescale 1ns/100ps
`default_nettype none
`include "fts_consts.svh"

module fts_lock_meter (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // feedback pulse pin and reference period in cycles
    input wire logic feedback,
    input wire logic [16:0] ref_period,
    // lock state and last measured period
    output logic lock,
    output logic [16:0] period
);

    logic fb_s1;
    logic fb_s2;
    logic fb_s3;
    logic [16:0] cnt;
    logic [16:0] next_cnt;
    logic [16:0] next_period;
    logic next_lock;
    logic edge_seen;
    logic [16:0] tol;
    logic [16:0] dev;

    function automatic logic [16:0] fts_absdiff(input logic [16:0] a,
                                                input logic [16:0] b);
        fts_absdiff = (a > b) ? a - b : b - a;
    endfunction

    always_comb begin
        edge_seen = fb_s2 && !fb_s3;
        tol = ref_period >> `FTS_LOCK_SHIFT;
        dev = fts_absdiff(cnt, ref_period);
        next_cnt = (cnt == `FTS_PERIOD_MAX) ? cnt : cnt + 17'h00001;
        next_period = period;
        next_lock = lock;
        if (edge_seen) begin
            next_cnt = 17'h00001;
            next_period = cnt;
            next_lock = dev <= tol;
        end else if ({1'b0, cnt} > {1'b0, ref_period} + {1'b0, tol}) begin
            // stalled rotor falls out of lock without waiting for an edge
            next_lock = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fb_s1 <= 1'b0;
            fb_s2 <= 1'b0;
            fb_s3 <= 1'b0;
            cnt <= 17'h00000;
            period <= 17'h00000;
            lock <= 1'b0;
        end else begin
            fb_s1 <= feedback;
            fb_s2 <= fb_s1;
            fb_s3 <= fb_s2;
            cnt <= next_cnt;
            period <= next_period;
            lock <= next_lock;
        end
    end

    a_lock_in_band: assert property (@(posedge clock)
        disable iff (!rst_b) edge_seen && dev <= tol |=> lock)
        else $error("lock not declared inside band");

    a_lock_out_band: assert property (@(posedge clock)
        disable iff (!rst_b) edge_seen && dev > tol |=> !lock)
        else $error("lock held outside band");

endmodule // fts_lock_meter
`default_nettype wire

// file: testbench/fts_motor_model.sv
`timescale 1ns/100ps
`default_nettype none

module fts_motor_model import fts_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // settings from the bench
    input wire fts_temps_t temps_set,
    input wire logic [16:0] fb_period,
    // command from the controller
    input wire logic fuser_motor_run_n,
    // sensor lines to the controller
    output var fts_temps_t temps_raw,
    output logic [2:0] hall,
    output logic rotation_feedback_pulse
);
    localparam logic [2:0] HALL_SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6,
                                            3'h4, 3'h5};
    logic [16:0] fb_cnt;
    logic [2:0] step_cnt;
    logic [2:0] pos;

    assign temps_raw = temps_set;
    assign hall = HALL_SEQ[pos];
    // no feedback edges while the rotor stands
    assign rotation_feedback_pulse = !fuser_motor_run_n
        && fb_period != '0 && fb_cnt < (fb_period >> 1);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fb_cnt <= '0;
            step_cnt <= '0;
            pos <= '0;
        end else if (!fuser_motor_run_n) begin
            fb_cnt <= (fb_cnt + 17'h00001 >= fb_period) ? '0
                : fb_cnt + 17'h00001;
            step_cnt <= step_cnt + 3'h1;
            if (step_cnt == 3'h7) begin
                pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
            end
        end
    end
endmodule // fts_motor_model

`default_nettype wire

// file: testbench/test_fuser_thermal_motor_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "fts_consts.svh"

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
    end \
end

module test_fuser_thermal_motor_supervisor import fts_pkg::*; ();
    logic clock, rst_b, read, write, waitrequest, irq, lock_led;
    logic fuser_motor_run_n, fuser_motor_slow_n, fuser_speed_ref_clock;
    logic rotation_feedback_pulse;
    logic [5:0] address, phase_drive;
    logic [31:0] writedata, readdata, q;
    logic [2:0] hall;
    logic [16:0] fb_period;
    fts_temps_t temps_raw, tset;
    int n_errors, tests_run, n;

    fts_top fts_top_i (.clock, .rst_b, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .irq, .temps_raw, .hall,
        .rotation_feedback_pulse, .fuser_motor_run_n, .fuser_motor_slow_n,
        .fuser_speed_ref_clock, .phase_drive, .lock_led);
    fts_motor_model fts_motor_model_i (.clock, .rst_b, .temps_set(tset),
        .fb_period, .fuser_motor_run_n, .temps_raw, .hall,
        .rotation_feedback_pulse);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic fts_temps_t mk(input int c, r, f, p);
        mk = {c[9:0], r[9:0], f[9:0], p[9:0]};
    endfunction

    // ------------------------------------------------
    // bus and helpers
    // ------------------------------------------------
    task automatic bus(input logic w, input logic [5:0] a,
            input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        // request stands until waitrequest is sampled low at a rising edge
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic fc(input logic [4:0] ph, input fts_temps_t t,
            input logic [15:0] code, input logic [7:0] cnt);
        bus(1'b1, `FTS_OFF_CTRL, {27'h0, ph});
        tset <= t;
        settle(6);
        bus(1'b0, `FTS_OFF_FAULT, 32'h0);
        `CHK(q[31], code != 16'h0000)
        if (code != 16'h0000) begin
            `CHK(q[23:0], {cnt, code})
            tset <= mk(-40, -40, -40, -40);
            settle(6);
            bus(1'b0, `FTS_OFF_FAULT, 32'h0);
            `CHK({q[31], q[23:0]}, {1'b1, cnt, code})
        end
        tset <= mk(200, 200, 200, 150);
        settle(4);
        bus(1'b1, `FTS_OFF_FAULT, 32'h0);
        bus(1'b0, `FTS_OFF_FAULT, 32'h0);
        `CHK(q[31], 1'b0)
    endtask

    task automatic irq_case();
        bus(1'b1, `FTS_OFF_IRQ_EN, 32'h0);
        bus(1'b1, `FTS_OFF_CTRL, 32'h2);
        bus(1'b1, `FTS_OFF_IRQ_CLR, 32'h7);
        tset <= mk(240, 200, 200, 150);
        @(posedge clock);
        tset <= mk(200, 200, 200, 150);
        settle(6);
        bus(1'b0, `FTS_OFF_FAULT, 32'h0);
        `CHK(q[31], 1'b0)
        // one-cycle detection is gone again, only its event stays
        bus(1'b0, `FTS_OFF_PEND, 32'h0);
        `CHK({q[31], q[23:0]}, {1'b0, 24'h0})
        bus(1'b0, `FTS_OFF_IRQ_STAT, 32'h0);
        `CHK(q[2:0], 3'h2)
        `CHK(irq, 1'b0)
        bus(1'b1, `FTS_OFF_IRQ_EN, 32'h2);
        settle(2);
        `CHK(irq, 1'b1)
        bus(1'b1, `FTS_OFF_IRQ_CLR, 32'h2);
        settle(2);
        `CHK(irq, 1'b0)
    endtask

    task automatic motor_case();
        bus(1'b1, `FTS_OFF_REF_HALF, 32'h14);
        fb_period <= 17'h00028;
        bus(1'b1, `FTS_OFF_CTRL, 32'h102);
        settle(300);
        `CHK({fuser_motor_run_n, fuser_motor_slow_n}, 2'b00)
        `CHK(|phase_drive, 1'b1)
        `CHK(lock_led, 1'b1)
        @(posedge fuser_speed_ref_clock);
        n = 0;
        @(negedge clock);
        while (fuser_speed_ref_clock === 1'b1 && n < 99) begin
            n++;
            @(negedge clock);
        end
        `CHK(n, 20)
        @(posedge clock);
        fb_period <= 17'h0002A;
        settle(300);
        `CHK(lock_led, 1'b1)
        @(posedge clock);
        fb_period <= 17'h0002B;
        settle(300);
        `CHK(lock_led, 1'b0)
        bus(1'b0, `FTS_OFF_IRQ_STAT, 32'h0);
        `CHK(q[2], 1'b1)
        bus(1'b1, `FTS_OFF_CTRL, 32'h104);
        settle(3);
        `CHK(fuser_motor_slow_n, 1'b1)
        bus(1'b1, `FTS_OFF_CTRL, 32'h304);
        settle(3);
        `CHK(fuser_motor_slow_n, 1'b0)
        bus(1'b1, `FTS_OFF_CTRL, 32'h004);
        settle(3);
        `CHK({fuser_motor_run_n, phase_drive}, 7'h40)
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        final_report();
    end

    initial begin
        rst_b = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        fb_period = '0;
        tset = mk(200, 200, 200, 150);
        n_errors = 0;
        tests_run = 0;
        repeat (2) @(posedge clock);
        `CHK({readdata, waitrequest, irq, lock_led}, 35'h4)
        `CHK({fuser_motor_run_n, fuser_motor_slow_n}, 2'h3)
        `CHK({fuser_speed_ref_clock, phase_drive}, 7'h00)
        rst_b <= 1'b1;
        bus(1'b0, `FTS_OFF_SLOW_REF, 32'h0);
        `CHK(q[9:0], `FTS_SLOW_REF_RST)
        bus(1'b0, `FTS_OFF_REF_HALF, 32'h0);
        `CHK(q[15:0], `FTS_REF_HALF_RST)
        bus(1'b0, 6'h3C, 32'h0);
        `CHK(q, 32'h0)
        irq_case();
        fc(FTS_IDLE, mk(300,300,300,300), 16'h0000, 8'h00);
        fc(FTS_READY, mk(239,249,269,1), 16'h0000, 8'h00);
        fc(FTS_READY,mk(240,40,200,150),`FTS_C449,`FTS_CNT_READY_HOT);
        fc(FTS_READY,mk(200,250,200,150),`FTS_C449,`FTS_CNT_READY_HOT);
        fc(FTS_READY,mk(200,200,40,150),`FTS_C447,`FTS_CNT_READY_COLD);
        fc(FTS_READY,mk(200,200,200,0),`FTS_C467,`FTS_CNT_READY_COLD);
        fc(FTS_PRINT,mk(200,200,270,150),`FTS_C449,`FTS_CNT_PRINT);
        fc(FTS_PRINT,mk(41,40,200,0),`FTS_C447,`FTS_CNT_PRINT);
        fc(FTS_PRINT,mk(200,200,200,0),`FTS_C467,`FTS_CNT_PRINT);
        fc(FTS_SAVE,mk(200,200,270,250),`FTS_C449,`FTS_CNT_SAVE_HOT);
        fc(FTS_SAVE,mk(200,200,200,250),`FTS_C468,`FTS_CNT_SAVE_PRESS);
        fc(FTS_SAVE, mk(200,200,200,249), 16'h0000, 8'h00);
        fc(FTS_JAM,mk(200,250,200,150),`FTS_C449,`FTS_CNT_JAM_HOT);
        fc(FTS_JAM,mk(200,200,200,250),`FTS_C468,`FTS_CNT_JAM_PRESS);
        motor_case();
        final_report();
    end
endmodule // test_fuser_thermal_motor_supervisor

`default_nettype wire
